// file: audio_serial_pkg.sv
package audio_serial_pkg;

    // ----------------------------------------------------------------
    // Register offsets (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [11:0] OFF_CONTROL      = 12'h000;
    localparam logic [11:0] OFF_STATUS       = 12'h004;
    localparam logic [11:0] OFF_FAULT_FLAGS  = 12'h008;
    localparam logic [11:0] OFF_LR_RATIO     = 12'h00C;
    localparam logic [11:0] OFF_TX_FIFO_PORT = 12'h010;
    localparam logic [11:0] OFF_RX_FIFO_PORT = 12'h014;
    localparam logic [11:0] OFF_TEST_MODE    = 12'h300;
    localparam logic [11:0] OFF_TEST_INPUT   = 12'h304;
    localparam logic [11:0] OFF_TEST_OUTPUT  = 12'h308;

    // ----------------------------------------------------------------
    // Control register fields
    // ----------------------------------------------------------------
    localparam int CTL_TX_EN       = 0;
    localparam int CTL_TX_IRQ_EN   = 1;
    localparam int CTL_RX_EN       = 2;
    localparam int CTL_RX_IRQ_EN   = 3;
    localparam int CTL_TX_WL_LSB   = 8;
    localparam int CTL_RX_WL_LSB   = 12;
    localparam int CTL_FIFO_FLUSH  = 16;
    localparam int CTL_CODEC_RESET = 17;
    localparam logic [31:0] CTL_WMASK = 32'h0003_770F;
    localparam logic [31:0] CTL_RESET = 32'h0000_2200;

    // ----------------------------------------------------------------
    // Fault flag, ratio and test register fields and resets
    // ----------------------------------------------------------------
    localparam int FLT_TX_FAULT = 0;
    localparam int FLT_RX_OVER  = 1;
    localparam logic [9:0] LR_RATIO_RESET = 10'h020;
    localparam logic [3:0] TEST_OUT_RESET = 4'h0;
    localparam int TOUT_SERIAL_OUT_DRIVE = 0;
    localparam int TOUT_SCLK  = 1;
    localparam int TOUT_WORD_SELECT_CLOCK  = 2;
    localparam int TOUT_IRQ   = 3;

    // ----------------------------------------------------------------
    // Buffers and serial framing
    // ----------------------------------------------------------------
    localparam int FIFO_DEPTH = 4;
    localparam int PTR_W      = 2;
    localparam int CNT_W      = 3;
    localparam logic [9:0] SAMPLE_BITS = 10'h010;

endpackage

// file: audio_serial_link_if.sv
`timescale 1ns/10ps
interface audio_serial_link_if;
    logic        tx_en;
    logic        rx_en;
    logic [9:0]  lr_clock_divider;
    logic        tx_valid;
    logic [31:0] tx_data;
    logic        tx_pop;
    logic        tx_underrun;
    logic        rx_push;
    logic [31:0] rx_data;
    logic        serial_in_sample;
    logic        eng_sclk;
    logic        eng_word_select;
    logic        eng_serial_out;

    modport regs (
        output tx_en, rx_en, lr_clock_divider, tx_valid, tx_data,
        output serial_in_sample,
        input  tx_pop, tx_underrun, rx_push, rx_data,
        input  eng_sclk, eng_word_select, eng_serial_out
    );
    modport engine (
        input  tx_en, rx_en, lr_clock_divider, tx_valid, tx_data,
        input  serial_in_sample,
        output tx_pop, tx_underrun, rx_push, rx_data,
        output eng_sclk, eng_word_select, eng_serial_out
    );
endinterface

// file: audio_serial_engine.sv
`timescale 1ns/10ps
module audio_serial_engine (
    // Clock and reset
    input  wire logic   clk_sys,
    input  wire logic   rst,
    // Link to register side
    audio_serial_link_if.engine lnk
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic        sclk;
        logic        ws;
        logic        sdo;
        logic [9:0]  bitcnt;
        logic [31:0] tx_sh;
        logic [31:0] rx_sh;
        logic        pop;
        logic        under;
        logic        push;
        logic [31:0] rx_word;
    } eng_t;

    localparam logic [9:0] SAMPLE_BITS = audio_serial_pkg::SAMPLE_BITS;

    eng_t s_q;
    eng_t s_d;
    logic run;
    logic in_slot;

    assign run     = lnk.tx_en | lnk.rx_en;
    assign in_slot = (s_q.bitcnt != 10'h000) && (s_q.bitcnt <= SAMPLE_BITS);

    // ----------------------------------------------------------------
    // Serial clock, word select and shifting
    // ----------------------------------------------------------------
    // Serial clock is half the system clock; one half-frame lasts the
    // programmed ratio in serial clocks. Ratios under 17 cut the sample.

    always_comb begin
        s_d       = s_q;
        s_d.pop   = 1'b0;
        s_d.under = 1'b0;
        s_d.push  = 1'b0;
        if (!run) begin
            s_d.sclk   = 1'b0;
            s_d.ws     = 1'b0;
            s_d.sdo    = 1'b0;
            s_d.bitcnt = 10'h000;
        end else begin
            s_d.sclk = ~s_q.sclk;
            if (!s_q.sclk) begin
                // Rising edge: the codec's data is stable, take it.
                if (in_slot) begin
                    s_d.rx_sh = {s_q.rx_sh[30:0], lnk.serial_in_sample};
                end
            end else begin
                // Falling edge: advance the slot and launch the next bit.
                s_d.bitcnt = s_q.bitcnt + 10'h001;
                if (s_q.bitcnt + 10'h001 >= lnk.lr_clock_divider) begin
                    s_d.bitcnt = 10'h000;
                    s_d.ws     = ~s_q.ws;
                    if (s_q.ws) begin
                        // New frame: swap the stereo words in and out.
                        s_d.tx_sh   = lnk.tx_valid ? lnk.tx_data : 32'h0;
                        s_d.pop     = lnk.tx_valid & lnk.tx_en;
                        s_d.under   = ~lnk.tx_valid & lnk.tx_en;
                        s_d.push    = lnk.rx_en;
                        s_d.rx_word = s_q.rx_sh;
                    end
                end
                s_d.sdo = 1'b0;
                if (s_d.bitcnt != 10'h000 && s_d.bitcnt <= SAMPLE_BITS) begin
                    s_d.sdo   = s_q.tx_sh[31];
                    s_d.tx_sh = {s_q.tx_sh[30:0], 1'b0};
                end
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign lnk.eng_sclk        = s_q.sclk;
    assign lnk.eng_word_select = s_q.ws;
    assign lnk.eng_serial_out  = s_q.sdo;
    assign lnk.tx_pop          = s_q.pop;
    assign lnk.tx_underrun     = s_q.under;
    assign lnk.rx_push         = s_q.push;
    assign lnk.rx_data         = s_q.rx_word;

endmodule

// file: audio_serial_port_regs.sv
`timescale 1ns/10ps
module audio_serial_port_regs (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst,
    // Peripheral register bus
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Codec pins
    input  wire logic        serial_data_in,
    output logic             serial_clock,
    output logic             word_select_clock,
    output logic             serial_out_drive,
    output logic             codec_reset,
    // Interrupt
    output logic             irq
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [31:0]                        ctrl;
        logic [1:0]                         fault;
        logic [9:0]                         ratio;
        logic                               test_mode_enable;
        logic [3:0]                         test_out;
        logic [audio_serial_pkg::FIFO_DEPTH-1:0][31:0] tx_mem;
        logic [audio_serial_pkg::PTR_W-1:0] tx_rd;
        logic [audio_serial_pkg::PTR_W-1:0] tx_wr;
        logic [audio_serial_pkg::CNT_W-1:0] tx_cnt;
        logic [audio_serial_pkg::FIFO_DEPTH-1:0][31:0] rx_mem;
        logic [audio_serial_pkg::PTR_W-1:0] rx_rd;
        logic [audio_serial_pkg::PTR_W-1:0] rx_wr;
        logic [audio_serial_pkg::CNT_W-1:0] rx_cnt;
        logic [31:0]                        rdata;
    } regs_t;

    localparam logic [2:0] DEPTH = 3'(audio_serial_pkg::FIFO_DEPTH);

    regs_t s_q;
    regs_t s_d;
    audio_serial_link_if lnk ();

    logic        wr_acc;
    logic        rd_acc;
    logic        rd_setup;
    logic        tx_full;
    logic        rx_empty;
    logic        tx_alert;
    logic        rx_alert;
    logic        irq_normal;
    logic [2:0]  tx_free;
    logic [2:0]  rx_free;
    logic [31:0] status;
    logic        tx_push;
    logic        rx_pop;
    logic        rx_push_ok;

    // Address match, reused by read and write decode.
    function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
        return a == o;
    endfunction

    // ----------------------------------------------------------------
    // Bus decode and derived status
    // ----------------------------------------------------------------
    assign wr_acc   = psel & penable & pwrite;
    assign rd_acc   = psel & penable & ~pwrite;
    assign rd_setup = psel & ~penable & ~pwrite;
    assign pready   = 1'b1;
    assign pslverr  = 1'b0;
    assign prdata   = s_q.rdata;

    assign tx_free  = DEPTH - s_q.tx_cnt;
    assign rx_free  = DEPTH - s_q.rx_cnt;
    assign tx_full  = s_q.tx_cnt == DEPTH;
    assign rx_empty = s_q.rx_cnt == 3'h0;
    // Alerts compare free word space against the programmed levels.
    assign tx_alert = tx_free > s_q.ctrl[audio_serial_pkg::CTL_TX_WL_LSB +: 3];
    assign rx_alert = rx_free < s_q.ctrl[audio_serial_pkg::CTL_RX_WL_LSB +: 3];
    assign status   = {26'h0, s_q.rx_cnt == DEPTH, rx_empty,
                       tx_full, s_q.tx_cnt == 3'h0, rx_alert, tx_alert};

    // A single level output; the system map gives each instance its line.
    assign irq_normal =
        (s_q.ctrl[audio_serial_pkg::CTL_TX_IRQ_EN] & tx_alert) |
        (s_q.ctrl[audio_serial_pkg::CTL_RX_IRQ_EN] & rx_alert);

    // Writes to a full transmit buffer are dropped and flagged.
    assign tx_push    = wr_acc & hit(paddr, audio_serial_pkg::OFF_TX_FIFO_PORT)
                        & ~tx_full;
    assign rx_pop     = rd_acc & hit(paddr, audio_serial_pkg::OFF_RX_FIFO_PORT)
                        & ~rx_empty;
    assign rx_push_ok = lnk.rx_push & (s_q.rx_cnt != DEPTH);

    // ----------------------------------------------------------------
    // Register and buffer update
    // ----------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        if (wr_acc) begin
            unique case (1'b1)
                hit(paddr, audio_serial_pkg::OFF_CONTROL): begin
                    s_d.ctrl = pwdata & audio_serial_pkg::CTL_WMASK;
                end
                hit(paddr, audio_serial_pkg::OFF_FAULT_FLAGS): begin
                    s_d.fault = s_q.fault & ~pwdata[1:0];
                end
                hit(paddr, audio_serial_pkg::OFF_LR_RATIO): begin
                    s_d.ratio = pwdata[9:0];
                end
                hit(paddr, audio_serial_pkg::OFF_TEST_MODE): begin
                    s_d.test_mode_enable = pwdata[0];
                end
                hit(paddr, audio_serial_pkg::OFF_TEST_OUTPUT): begin
                    s_d.test_out = pwdata[3:0];
                end
                default: begin
                end
            endcase
        end
        // Set wins over a same-cycle clear.
        if (wr_acc && hit(paddr, audio_serial_pkg::OFF_TX_FIFO_PORT)
            && tx_full) begin
            s_d.fault[audio_serial_pkg::FLT_TX_FAULT] = 1'b1;
        end
        if (lnk.tx_underrun) begin
            s_d.fault[audio_serial_pkg::FLT_TX_FAULT] = 1'b1;
        end
        if (lnk.rx_push && !rx_push_ok) begin
            s_d.fault[audio_serial_pkg::FLT_RX_OVER] = 1'b1;
        end
        // Transmit buffer: left sample high, right sample low, one word.
        if (tx_push) begin
            s_d.tx_mem[s_q.tx_wr] = {pwdata[31:16], pwdata[15:0]};
            s_d.tx_wr = s_q.tx_wr + 2'h1;
        end
        if (lnk.tx_pop) begin
            s_d.tx_rd = s_q.tx_rd + 2'h1;
        end
        s_d.tx_cnt = s_q.tx_cnt + {2'h0, tx_push} - {2'h0, lnk.tx_pop};
        // Receive buffer, filled by the serial engine.
        if (rx_push_ok) begin
            s_d.rx_mem[s_q.rx_wr] = lnk.rx_data;
            s_d.rx_wr = s_q.rx_wr + 2'h1;
        end
        if (rx_pop) begin
            s_d.rx_rd = s_q.rx_rd + 2'h1;
        end
        s_d.rx_cnt = s_q.rx_cnt + {2'h0, rx_push_ok} - {2'h0, rx_pop};
        // Flush holds both buffers empty while the bit stays set.
        if (s_q.ctrl[audio_serial_pkg::CTL_FIFO_FLUSH]) begin
            s_d.tx_rd  = 2'h0;
            s_d.tx_wr  = 2'h0;
            s_d.tx_cnt = 3'h0;
            s_d.rx_rd  = 2'h0;
            s_d.rx_wr  = 2'h0;
            s_d.rx_cnt = 3'h0;
        end
        // Read data is captured in the setup phase and shown in access.
        s_d.rdata = 32'h0;
        if (rd_setup) begin
            unique case (1'b1)
                hit(paddr, audio_serial_pkg::OFF_CONTROL):
                    s_d.rdata = s_q.ctrl;
                hit(paddr, audio_serial_pkg::OFF_STATUS):
                    s_d.rdata = status;
                hit(paddr, audio_serial_pkg::OFF_FAULT_FLAGS):
                    s_d.rdata = {30'h0, s_q.fault};
                hit(paddr, audio_serial_pkg::OFF_LR_RATIO):
                    s_d.rdata = {22'h0, s_q.ratio};
                hit(paddr, audio_serial_pkg::OFF_RX_FIFO_PORT):
                    s_d.rdata = rx_empty ? 32'h0
                                         : s_q.rx_mem[s_q.rx_rd];
                hit(paddr, audio_serial_pkg::OFF_TEST_MODE):
                    s_d.rdata = {31'h0, s_q.test_mode_enable};
                hit(paddr, audio_serial_pkg::OFF_TEST_INPUT):
                    s_d.rdata = {31'h0, serial_data_in};
                hit(paddr, audio_serial_pkg::OFF_TEST_OUTPUT):
                    s_d.rdata = {28'h0, s_q.test_out};
                default: begin
                    s_d.rdata = 32'h0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s_q       <= '0;
            s_q.ctrl  <= audio_serial_pkg::CTL_RESET;
            s_q.ratio <= audio_serial_pkg::LR_RATIO_RESET;
            s_q.test_out <= audio_serial_pkg::TEST_OUT_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // ----------------------------------------------------------------
    // Serial engine and pin selection
    // ----------------------------------------------------------------
    assign lnk.tx_en            = s_q.ctrl[audio_serial_pkg::CTL_TX_EN];
    assign lnk.rx_en            = s_q.ctrl[audio_serial_pkg::CTL_RX_EN];
    assign lnk.lr_clock_divider = s_q.ratio;
    assign lnk.tx_valid         = s_q.tx_cnt != 3'h0;
    assign lnk.tx_data          = s_q.tx_mem[s_q.tx_rd];
    assign lnk.serial_in_sample = serial_data_in;

    audio_serial_engine u_engine (
        .clk_sys (clk_sys),
        .rst     (rst),
        .lnk     (lnk)
    );

    // Test mode overrides every output pin but codec_reset so a board test can wiggle them.
    assign serial_clock      = s_q.test_mode_enable
        ? s_q.test_out[audio_serial_pkg::TOUT_SCLK] : lnk.eng_sclk;
    assign word_select_clock = s_q.test_mode_enable
        ? s_q.test_out[audio_serial_pkg::TOUT_WORD_SELECT_CLOCK]
        : lnk.eng_word_select;
    assign serial_out_drive  = s_q.test_mode_enable
        ? s_q.test_out[audio_serial_pkg::TOUT_SERIAL_OUT_DRIVE]
        : lnk.eng_serial_out;
    assign irq               = s_q.test_mode_enable
        ? s_q.test_out[audio_serial_pkg::TOUT_IRQ] : irq_normal;
    assign codec_reset = s_q.ctrl[audio_serial_pkg::CTL_CODEC_RESET];

endmodule

// file: audio_serial_port_regs_assertions.sv
`timescale 1ns/10ps
module audio_serial_port_regs_assertions (
    // Clock and reset
    input wire logic        clk_sys,
    input wire logic        rst,
    // Register bus
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    // Pins
    input wire logic        serial_data_in,
    input wire logic        serial_clock,
    input wire logic        word_select_clock,
    input wire logic        serial_out_drive,
    input wire logic        codec_reset,
    input wire logic        irq
);
    logic [31:0] ctl_q;
    logic [9:0]  ratio_q;
    logic        tm_q;
    logic [3:0]  to_q;
    logic        ws_q;
    logic        ws_ok_q;
    logic [10:0] ws_cnt_q;
    wire         wr_en = psel && penable && pwrite;
    wire         run = (ctl_q[0] || ctl_q[2]) && !tm_q;

    // Shadow copies of the writable fields. Any write restarts the word
    // clock count, since a new ratio makes the running half frame odd.
    always_ff @(posedge clk_sys) begin
        ws_q <= word_select_clock;
        if (rst) begin
            ctl_q    <= audio_serial_pkg::CTL_RESET;
            ratio_q  <= audio_serial_pkg::LR_RATIO_RESET;
            tm_q     <= 1'b0;
            to_q     <= 4'h0;
            ws_ok_q  <= 1'b0;
            ws_cnt_q <= 11'h000;
        end else begin
            if (wr_en) begin
                case (paddr)
                    audio_serial_pkg::OFF_CONTROL:     ctl_q   <= pwdata;
                    audio_serial_pkg::OFF_LR_RATIO:    ratio_q <= pwdata[9:0];
                    audio_serial_pkg::OFF_TEST_MODE:   tm_q    <= pwdata[0];
                    audio_serial_pkg::OFF_TEST_OUTPUT: to_q    <= pwdata[3:0];
                    default: ;
                endcase
            end
            if (!run || wr_en) begin
                ws_ok_q  <= 1'b0;
                ws_cnt_q <= 11'h000;
            end else if (word_select_clock != ws_q) begin
                ws_ok_q  <= 1'b1;
                ws_cnt_q <= 11'h000;
            end else begin
                ws_cnt_q <= ws_cnt_q + 11'h001;
            end
        end
    end

    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);

    sequence rd_setup(logic [11:0] a);
        psel && !penable && !pwrite && paddr == a;
    endsequence
    sequence irq_off;
        !tm_q && !ctl_q[1] && !ctl_q[3];
    endsequence

    ratio_read_a: assert property (
        rd_setup(audio_serial_pkg::OFF_LR_RATIO) |=> prdata == {22'h0, ratio_q})
        else $error("ratio readback differs");
    ws_period_a: assert property (
        run && ws_ok_q && word_select_clock != ws_q
        |-> ws_cnt_q == {ratio_q, 1'b0} - 11'h001)
        else $error("word clock half period differs from ratio");
    mode_read_a: assert property (
        rd_setup(audio_serial_pkg::OFF_TEST_MODE) |=> prdata == {31'h0, tm_q})
        else $error("test enable readback differs");
    sense_read_a: assert property (
        $stable(serial_data_in)[*3] ##0 rd_setup(audio_serial_pkg::OFF_TEST_INPUT)
        |=> prdata == {31'h0, $past(serial_data_in)})
        else $error("test input does not show data pin");
    drive_read_a: assert property (
        rd_setup(audio_serial_pkg::OFF_TEST_OUTPUT) |=> prdata == {28'h0, to_q})
        else $error("test drive readback differs");
    test_pins_a: assert property (
        (tm_q && $stable(to_q))[*2] |-> {irq, word_select_clock,
        serial_clock, serial_out_drive} == to_q)
        else $error("pins do not follow test drive in test mode");
    codec_pin_a: assert property (
        $stable(ctl_q[17])[*2] |-> codec_reset == ctl_q[17])
        else $error("codec reset pin differs from control bit");
    irq_quiet_a: assert property (
        irq_off[*2] |-> !irq)
        else $error("interrupt raised with both enables off");
endmodule

bind audio_serial_port_regs audio_serial_port_regs_assertions chk (
    .clk_sys, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .serial_data_in, .serial_clock, .word_select_clock, .serial_out_drive,
    .codec_reset, .irq
);

// file: codec_model.sv
`timescale 1ns/10ps
// Stereo codec: returns rx_word every frame and records what it hears.
module codec_model (
    // Serial pins
    input  wire logic        sclk,
    input  wire logic        ws,
    input  wire logic        sdo,
    output logic             sdi,
    // Bench controls
    input  wire logic [31:0] rx_word,
    input  wire logic        hold_en,
    input  wire logic        hold_val,
    // Captured frames
    output logic [31:0]      frame_word,
    output int               frame_cnt
);
    int          slot = 99;
    int          n;
    time         t_last = 0;
    logic        ws_q = 1'b0;
    logic        left_ok = 1'b0;
    logic [15:0] sh = 16'h0000;
    logic [15:0] left = 16'h0000;
    logic        drv = 1'b0;

    // The line is parked at a steady level only when the bench asks.
    assign sdi = hold_en ? hold_val : drv;
    initial frame_word = 32'h0000_0000;
    initial frame_cnt = 0;

    // Slot zero is the first rise after a word clock edge or a long gap,
    // so a frame that begins with the enable is still understood.
    always @(posedge sclk) begin
        n = (ws != ws_q || $time - t_last > 200) ? 0 : slot + 1;
        if (ws != ws_q && !ws && left_ok) begin
            frame_word <= {left, sh};
            frame_cnt <= frame_cnt + 1;
        end
        if (n == 0 && !ws) begin
            left_ok <= 1'b0;
        end
        if (n >= 1 && n <= 16) begin
            sh <= {sh[14:0], sdo};
        end
        if (n == 16 && !ws) begin
            left <= {sh[14:0], sdo};
            left_ok <= 1'b1;
        end
        slot <= n;
        ws_q <= ws;
        t_last <= $time;
    end

    // Outside the data slots the line toggles, so a stale bit never
    // passes for a good one.
    always @(negedge sclk) begin
        drv <= (slot <= 15) ? rx_word[(ws_q ? 15 : 31) - slot] : ~drv;
    end
endmodule

// file: audio_serial_port_regs_tb_top.sv
`timescale 1ns/10ps
module audio_serial_port_regs_tb_top;
    logic        clk_sys = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready;
    logic        sdi, sclk, ws, sdo, codec_reset, irq;
    logic        hold_en = 1'b1;
    logic        hold_val = 1'b0;
    logic [31:0] rx_word = 32'h0000_0000;
    logic [31:0] frame_word;
    logic [31:0] seed = 32'h0000_1C42;
    logic [31:0] v;
    int          frame_cnt;
    int          n_fail = 0;
    int          n_tests = 0;
    logic [31:0] rd_exp[$], rd_msk[$], tx_exp[$];
    logic [31:0] ctl_tab[5] = '{32'h0000_0302, 32'h0000_0402,
                                32'h0000_5008, 32'h0000_4008, 32'h0002_0000};
    logic        irq_tab[5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};

    audio_serial_port_regs dut (
        .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(), .serial_data_in(sdi),
        .serial_clock(sclk), .word_select_clock(ws),
        .serial_out_drive(sdo), .codec_reset(codec_reset), .irq(irq)
    );
    codec_model codec (
        .sclk(sclk), .ws(ws), .sdo(sdo), .sdi(sdi), .rx_word(rx_word),
        .hold_en(hold_en), .hold_val(hold_val),
        .frame_word(frame_word), .frame_cnt(frame_cnt)
    );

    always #20 clk_sys = ~clk_sys;

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Unmatched notes count as failures.
    task automatic end_of_test();
        n_fail += rd_exp.size() + tx_exp.size();
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // One transfer, held until pready is seen high.
    task automatic bus(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int i;
        i = 0;
        @(negedge clk_sys);
        psel = 1'b1;
        pwrite = w;
        paddr = a;
        pwdata = d;
        @(negedge clk_sys);
        penable = 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1 && i < 16) begin
            @(posedge clk_sys);
            i++;
        end
        if (i == 16) begin
            n_fail++;
            end_of_test();
        end
        @(negedge clk_sys);
        psel = 1'b0;
        penable = 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] e,
                      input logic [31:0] m = 32'hFFFF_FFFF);
        rd_exp.push_back(e & m);
        rd_msk.push_back(m);
        bus(1'b0, a, 32'h0000_0000);
    endtask

    // Read data stands from the setup edge through the access phase.
    always @(posedge clk_sys) begin
        if (psel && !penable && !pwrite && rd_exp.size() > 0) begin
            #10;
            check(prdata & rd_msk.pop_front(), rd_exp.pop_front());
        end
    end

    // Zero frames from an underrun are skipped.
    always @(frame_cnt) begin
        if (frame_word !== 32'h0000_0000 && tx_exp.size() > 0)
            check(frame_word, tx_exp.pop_front());
    end

    initial begin
        repeat (10) @(negedge clk_sys);
        rst = 1'b0;
        bus(1'b1, 12'hFF0, 32'hFFFF_FFFF);
        bus(1'b1, audio_serial_pkg::OFF_RX_FIFO_PORT, 32'hFFFF_FFFF);
        rd(audio_serial_pkg::OFF_LR_RATIO, 32'h0000_0020);
        rd(audio_serial_pkg::OFF_STATUS, 32'h0000_0015);
        rd(audio_serial_pkg::OFF_FAULT_FLAGS, 32'h0000_0000);
        rd(audio_serial_pkg::OFF_RX_FIFO_PORT, 32'h0000_0000);
        rd(audio_serial_pkg::OFF_TEST_MODE, 32'h0000_0000);
        rd(audio_serial_pkg::OFF_TEST_OUTPUT, 32'h0000_0000);
        rd(12'hFF0, 32'h0000_0000);
        $display("reset values done");
        for (int i = 0; i < 4; i++) begin
            v = xs();
            bus(1'b1, audio_serial_pkg::OFF_LR_RATIO, v);
            rd(audio_serial_pkg::OFF_LR_RATIO, {22'h0, v[9:0]});
        end
        $display("ratio done");
        bus(1'b1, audio_serial_pkg::OFF_TEST_MODE, 32'hFFFF_FFFF);
        rd(audio_serial_pkg::OFF_TEST_MODE, 32'h0000_0001);
        for (int i = 0; i < 6; i++) begin
            v = xs();
            hold_val = v[4];
            bus(1'b1, audio_serial_pkg::OFF_TEST_OUTPUT, v);
            rd(audio_serial_pkg::OFF_TEST_OUTPUT, {28'h0, v[3:0]});
            rd(audio_serial_pkg::OFF_TEST_INPUT, {31'h0, v[4]});
            check({28'h0, irq, ws, sclk, sdo}, {28'h0, v[3:0]});
        end
        bus(1'b1, audio_serial_pkg::OFF_TEST_MODE, 32'h0000_0000);
        $display("test mode done");
        for (int i = 0; i < 5; i++) begin
            bus(1'b1, audio_serial_pkg::OFF_CONTROL, ctl_tab[i]);
            repeat (2) @(negedge clk_sys);
            check({31'h0, irq}, {31'h0, irq_tab[i]});
        end
        check({31'h0, codec_reset}, 32'h0000_0001);
        $display("interrupt levels done");
        // A ratio of 17 is the shortest that carries a whole sample.
        rx_word = xs();
        v = xs() | 32'h0000_0001;
        hold_en = 1'b0;
        bus(1'b1, audio_serial_pkg::OFF_LR_RATIO, 32'h0000_0011);
        tx_exp.push_back(v);
        bus(1'b1, audio_serial_pkg::OFF_TX_FIFO_PORT, v);
        bus(1'b1, audio_serial_pkg::OFF_CONTROL, 32'h0000_0005);
        repeat (600) @(negedge clk_sys);
        bus(1'b1, audio_serial_pkg::OFF_CONTROL, 32'h0000_0000);
        rd(audio_serial_pkg::OFF_FAULT_FLAGS, 32'h0000_0003);
        bus(1'b1, audio_serial_pkg::OFF_FAULT_FLAGS, 32'h0000_0001);
        rd(audio_serial_pkg::OFF_FAULT_FLAGS, 32'h0000_0002);
        bus(1'b1, audio_serial_pkg::OFF_FAULT_FLAGS, 32'h0000_0002);
        rd(audio_serial_pkg::OFF_FAULT_FLAGS, 32'h0000_0000);
        rd(audio_serial_pkg::OFF_RX_FIFO_PORT, 32'h0, 32'h0);
        repeat (3) rd(audio_serial_pkg::OFF_RX_FIFO_PORT, rx_word);
        $display("traffic done");
        repeat (4) @(negedge clk_sys);
        end_of_test();
    end
endmodule
